// [rtl/twec_params.svh]
// Constants of the two-wire event control block.
// Assumes inclusion by bare name from the design files.
`ifndef TWEC_PARAMS_SVH
`define TWEC_PARAMS_SVH
// Status codes, event codes sit above the low three bits
`define TWEC_ST_NO_INFO 8'hF8
`define TWEC_ST_BUS_ERR 8'h00
`define TWEC_ST_START 8'h08
`define TWEC_ST_RSTART 8'h10
`define TWEC_ST_ATX_ACK 8'h18
`define TWEC_ST_ATX_NACK 8'h20
`define TWEC_ST_DTX_ACK 8'h28
`define TWEC_ST_DTX_NACK 8'h30
`define TWEC_ST_ARB 8'h38
`define TWEC_ST_OWN 8'h60
`define TWEC_ST_GC 8'h70
`define TWEC_ST_DRX 8'h80
`define TWEC_ST_STOP_RX 8'hA0
`define TWEC_STATUS_MASK 8'hF8
`define TWEC_GC_ADDR 7'h00
// Event word fields
`define TWEC_EVW_ACK 0
`define TWEC_EVW_BYTE_LO 1
`define TWEC_EVW_BYTE_HI 8
`define TWEC_EVW_KIND_LO 9
`define TWEC_EVW_KIND_HI 12
`define TWEC_EVW_W 13
`define TWEC_BUF_DEPTH 2
`endif

// [rtl/twec_pkg.sv]
// Types of the two-wire event control block.
// Assumes nothing of its surroundings.
package twec_pkg;
  typedef enum logic [3:0] {
    EV_START_TX = 4'h0,
    EV_RSTART_TX = 4'h1,
    EV_ADDR_TX = 4'h2,
    EV_DATA_TX = 4'h3,
    EV_ARB_LOST = 4'h4,
    EV_ADDR_RX = 4'h5,
    EV_DATA_RX = 4'h6,
    EV_STOP_RX = 4'h7,
    EV_BUS_ERR = 4'h8,
    EV_STOP_TX = 4'h9
  } twec_ev_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOAD = 2'b01,
    S_HOLD = 2'b10
  } twec_state_t;
  typedef enum logic [2:0] {
    CMD_START = 3'b000,
    CMD_STOP = 3'b001,
    CMD_SEND = 3'b010,
    CMD_RECV = 3'b011,
    CMD_ADDR_ANS = 3'b100,
    CMD_ABORT = 3'b101
  } twec_cmd_t;
endpackage

// [rtl/twec_top.sv]
// Event flag, status and address match of the two-wire interface.
// Assumes a bus unit on LINK_CLK that reports byte-level events
// and takes commands; CPU side is plain strobes on CLK.
`timescale 1ns/1ps
`include "twec_params.svh"
module twec_top #(
  parameter int DEPTH = `TWEC_BUF_DEPTH
) (
  // System
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Link side
  input wire logic LINK_CLK,
  input wire logic EV_VALID,
  input wire logic [3:0] EV_KIND,
  input wire logic [7:0] EV_BYTE,
  input wire logic EV_ACK,
  output logic EV_READY,
  output logic CMD_VALID,
  output logic [2:0] CMD_CODE,
  output logic [7:0] CMD_BYTE,
  output logic CMD_ACK_EN,
  input wire logic CMD_READY,
  // Clock line stretch
  output logic SCL_O,
  output logic SCL_OE_N,
  // Control register
  input wire logic CTRL_WE,
  input wire logic CTRL_FLAG_W1C,
  input wire logic CTRL_START,
  input wire logic CTRL_STOP,
  input wire logic CTRL_ACK_EN,
  input wire logic CTRL_ENABLE,
  input wire logic CTRL_IRQ_EN,
  input wire logic GLOBAL_IE,
  // Own address and data
  input wire logic [6:0] OWN_ADDR,
  input wire logic GC_ENABLE,
  input wire logic DATA_WE,
  input wire logic [7:0] DATA_WDATA,
  output logic [7:0] DATA_RDATA,
  // Status and power
  output logic FLAG,
  output logic [7:0] STATUS,
  output logic IRQ,
  input wire logic SLEEP,
  input wire logic OTHER_WAKE,
  output logic ADDR_WAKE
);

  localparam int AW = $clog2(DEPTH);
  localparam int EW = `TWEC_EVW_W;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////
  // Link domain: event capture and command hand-off

  logic ev_req_lr;
  logic ev_req_nxt;
  logic [EW-1:0] ev_word_lr;
  logic [EW-1:0] ev_word_nxt;
  logic cmd_ack_lr;
  logic cmd_ack_nxt;
  logic [2:0] evack_sync_lr;
  logic [2:0] cmdreq_sync_lr;
  logic ev_ready_l;
  logic cmd_pend_l;
  logic ev_ack_r;
  logic cmd_req_r;

  // Ready only once the acknowledge has settled in two stages
  assign ev_ready_l = (evack_sync_lr[1] == evack_sync_lr[2]) &&
                      (evack_sync_lr[2] == ev_req_lr);
  assign cmd_pend_l = (cmdreq_sync_lr[1] == cmdreq_sync_lr[2]) &&
                      (cmdreq_sync_lr[2] != cmd_ack_lr);

  always_comb begin
    ev_req_nxt = ev_req_lr;
    ev_word_nxt = ev_word_lr;
    cmd_ack_nxt = cmd_ack_lr;
    if (EV_VALID && ev_ready_l) begin
      ev_req_nxt = ~ev_req_lr;
      ev_word_nxt = {EV_KIND, EV_BYTE, EV_ACK};
    end
    if (cmd_pend_l && CMD_READY) begin
      cmd_ack_nxt = ~cmd_ack_lr;
    end
  end

  // Not frozen by CE: that enable belongs to the CPU clock
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      ev_req_lr <= 1'b0;
      ev_word_lr <= '0;
      cmd_ack_lr <= 1'b0;
      evack_sync_lr <= 3'h0;
      cmdreq_sync_lr <= 3'h0;
    end else begin
      ev_req_lr <= ev_req_nxt;
      ev_word_lr <= ev_word_nxt;
      cmd_ack_lr <= cmd_ack_nxt;
      evack_sync_lr <= {evack_sync_lr[1:0], ev_ack_r};
      cmdreq_sync_lr <= {cmdreq_sync_lr[1:0], cmd_req_r};
    end
  end

  assign EV_READY = ev_ready_l;
  assign CMD_VALID = cmd_pend_l;

  //////////////////////////////////////////////////////////////////
  // CPU domain state

  logic [2:0] evreq_sync_r;
  logic [2:0] cmdack_sync_r;
  logic ev_ack_nxt;
  logic cmd_req_nxt;
  twec_pkg::twec_state_t state_r;
  twec_pkg::twec_state_t state_nxt;
  logic [7:0] code_r;
  logic [7:0] code_nxt;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic ack_en_r;
  logic ack_en_nxt;
  logic irq_en_r;
  logic irq_en_nxt;
  logic en_r;
  logic en_nxt;
  logic loaded_r;
  logic loaded_nxt;
  logic sleep_match_r;
  logic sleep_match_nxt;
  twec_pkg::twec_cmd_t cmd_code_r;
  twec_pkg::twec_cmd_t cmd_code_nxt;
  logic [7:0] cmd_byte_r;
  logic [7:0] cmd_byte_nxt;
  logic cmd_acken_r;
  logic cmd_acken_nxt;
  logic [EW-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] wr_ptr_nxt;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] rd_ptr_nxt;

  logic buf_full;
  logic buf_empty;
  logic push;
  logic pop;
  logic cmd_busy;
  logic clr_c;
  logic abort_c;
  logic set_c;
  logic [7:0] evcode_c;
  logic match_own;
  logic match_gc;
  logic [EW-1:0] head;
  twec_pkg::twec_ev_t hk;
  logic [7:0] hb;
  logic ha;

  //////////////////////////////////////////////////////////////////
  // DEPTH-entry event buffer (two by default); a stalled drain backs up to EV_READY

  assign buf_empty = (wr_ptr_r == rd_ptr_r);
  assign buf_full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && !buf_empty;
  assign push = (evreq_sync_r[1] == evreq_sync_r[2]) &&
                (evreq_sync_r[2] != ev_ack_r) && !buf_full;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          mem_r[gi] <= '0;
        end else if (CE && push && wr_ptr_r[AW-1:0] == AW'(gi)) begin
          mem_r[gi] <= ev_word_lr;
        end
      end
    end
  endgenerate

  assign head = mem_r[rd_ptr_r[AW-1:0]];
  assign hk = twec_pkg::twec_ev_t'(head[`TWEC_EVW_KIND_HI:`TWEC_EVW_KIND_LO]);
  assign hb = head[`TWEC_EVW_BYTE_HI:`TWEC_EVW_BYTE_LO];
  assign ha = head[`TWEC_EVW_ACK];

  //////////////////////////////////////////////////////////////////
  // Control unit

  assign cmd_busy = !((cmdack_sync_r[1] == cmdack_sync_r[2]) &&
                      (cmdack_sync_r[2] == cmd_req_r));
  assign clr_c = CTRL_WE && CTRL_FLAG_W1C;
  assign abort_c = SLEEP && OTHER_WAKE && sleep_match_r;
  assign pop = (state_r == twec_pkg::S_IDLE) && !buf_empty &&
               !cmd_busy && !CTRL_WE;
  assign match_own = (hb[7:1] == OWN_ADDR);
  assign match_gc = GC_ENABLE && (hb[7:1] == `TWEC_GC_ADDR);

  always_comb begin
    ev_ack_nxt = ev_ack_r;
    cmd_req_nxt = cmd_req_r;
    state_nxt = state_r;
    code_nxt = code_r;
    stat_nxt = stat_r;
    data_nxt = data_r;
    ack_en_nxt = ack_en_r;
    irq_en_nxt = irq_en_r;
    en_nxt = en_r;
    loaded_nxt = loaded_r;
    sleep_match_nxt = sleep_match_r;
    cmd_code_nxt = cmd_code_r;
    cmd_byte_nxt = cmd_byte_r;
    cmd_acken_nxt = cmd_acken_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    set_c = 1'b0;
    evcode_c = `TWEC_ST_NO_INFO;
    if (CTRL_WE) begin
      ack_en_nxt = CTRL_ACK_EN;
      irq_en_nxt = CTRL_IRQ_EN;
      en_nxt = CTRL_ENABLE;
    end
    if (DATA_WE) begin
      data_nxt = DATA_WDATA;
      loaded_nxt = 1'b1;
    end
    if (push) begin
      ev_ack_nxt = ~ev_ack_r;
      wr_ptr_nxt = wr_ptr_r + (AW + 1)'(1);
    end
    // status follows flag by one cycle
    case (state_r)
      twec_pkg::S_IDLE: stat_nxt = `TWEC_ST_NO_INFO;
      twec_pkg::S_LOAD: begin
        stat_nxt = code_r;
        state_nxt = twec_pkg::S_HOLD;
      end
      twec_pkg::S_HOLD: stat_nxt = stat_r;
      default: state_nxt = twec_pkg::S_IDLE;
    endcase
    if (pop) begin
      rd_ptr_nxt = rd_ptr_r + (AW + 1)'(1);
      if (en_r) begin
        case (hk)
          twec_pkg::EV_START_TX: begin
            set_c = 1'b1;
            evcode_c = `TWEC_ST_START;
          end
          twec_pkg::EV_RSTART_TX: begin
            set_c = 1'b1;
            evcode_c = `TWEC_ST_RSTART;
          end
          twec_pkg::EV_ADDR_TX: begin
            set_c = 1'b1;
            evcode_c = ha ? `TWEC_ST_ATX_ACK : `TWEC_ST_ATX_NACK;
          end
          twec_pkg::EV_DATA_TX: begin
            set_c = 1'b1;
            evcode_c = ha ? `TWEC_ST_DTX_ACK : `TWEC_ST_DTX_NACK;
          end
          twec_pkg::EV_ARB_LOST: begin
            set_c = 1'b1;
            evcode_c = `TWEC_ST_ARB;
          end
          twec_pkg::EV_ADDR_RX: begin
            cmd_req_nxt = ~cmd_req_r;
            cmd_code_nxt = twec_pkg::CMD_ADDR_ANS;
            cmd_byte_nxt = hb;
            cmd_acken_nxt = (match_own || match_gc) && ack_en_r;
            if ((match_own || match_gc) && ack_en_r) begin
              set_c = 1'b1;
              evcode_c = match_own ? `TWEC_ST_OWN : `TWEC_ST_GC;
              data_nxt = hb;
              // match while asleep wakes the CPU
              sleep_match_nxt = SLEEP;
            end
          end
          twec_pkg::EV_DATA_RX: begin
            set_c = 1'b1;
            evcode_c = `TWEC_ST_DRX;
            data_nxt = hb;
          end
          twec_pkg::EV_STOP_RX: begin
            set_c = 1'b1;
            evcode_c = `TWEC_ST_STOP_RX;
          end
          twec_pkg::EV_BUS_ERR: begin
            set_c = 1'b1;
            evcode_c = `TWEC_ST_BUS_ERR;
          end
          default: set_c = 1'b0;
        endcase
      end
    end
    if (set_c) begin
      state_nxt = twec_pkg::S_LOAD;
      code_nxt = evcode_c;
    end
    if (clr_c) begin
      state_nxt = twec_pkg::S_IDLE;
      stat_nxt = `TWEC_ST_NO_INFO;
      sleep_match_nxt = 1'b0;
      loaded_nxt = DATA_WE;
      if (CTRL_ENABLE && !cmd_busy) begin
        cmd_req_nxt = ~cmd_req_r;
        cmd_byte_nxt = data_nxt;
        cmd_acken_nxt = CTRL_ACK_EN;
        if (CTRL_STOP) begin
          cmd_code_nxt = twec_pkg::CMD_STOP;
        end else if (CTRL_START) begin
          cmd_code_nxt = twec_pkg::CMD_START;
        end else if (loaded_r || DATA_WE) begin
          cmd_code_nxt = twec_pkg::CMD_SEND;
        end else begin
          cmd_code_nxt = twec_pkg::CMD_RECV;
        end
      end
    end
    if (abort_c) begin
      state_nxt = twec_pkg::S_IDLE;
      stat_nxt = `TWEC_ST_NO_INFO;
      sleep_match_nxt = 1'b0;
      if (!cmd_busy) begin
        cmd_req_nxt = ~cmd_req_r;
        cmd_code_nxt = twec_pkg::CMD_ABORT;
      end
    end
  end

  // reset leaves flag clear, no-information status
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      evreq_sync_r <= 3'h0;
      cmdack_sync_r <= 3'h0;
      ev_ack_r <= 1'b0;
      cmd_req_r <= 1'b0;
      state_r <= twec_pkg::S_IDLE;
      code_r <= `TWEC_ST_NO_INFO;
      stat_r <= `TWEC_ST_NO_INFO;
      data_r <= 8'h00;
      ack_en_r <= 1'b0;
      irq_en_r <= 1'b0;
      en_r <= 1'b0;
      loaded_r <= 1'b0;
      sleep_match_r <= 1'b0;
      cmd_code_r <= twec_pkg::CMD_START;
      cmd_byte_r <= 8'h00;
      cmd_acken_r <= 1'b0;
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (CE) begin
      evreq_sync_r <= {evreq_sync_r[1:0], ev_req_lr};
      cmdack_sync_r <= {cmdack_sync_r[1:0], cmd_ack_lr};
      ev_ack_r <= ev_ack_nxt;
      cmd_req_r <= cmd_req_nxt;
      state_r <= state_nxt;
      code_r <= code_nxt;
      stat_r <= stat_nxt;
      data_r <= data_nxt;
      ack_en_r <= ack_en_nxt;
      irq_en_r <= irq_en_nxt;
      en_r <= en_nxt;
      loaded_r <= loaded_nxt;
      sleep_match_r <= sleep_match_nxt;
      cmd_code_r <= cmd_code_nxt;
      cmd_byte_r <= cmd_byte_nxt;
      cmd_acken_r <= cmd_acken_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Outputs

  assign FLAG = (state_r != twec_pkg::S_IDLE);
  assign STATUS = stat_r;
  assign DATA_RDATA = data_r;
  assign IRQ = FLAG && irq_en_r && GLOBAL_IE;
  assign SCL_O = 1'b0;
  assign SCL_OE_N = ~FLAG;
  assign ADDR_WAKE = sleep_match_r;
  assign CMD_CODE = cmd_code_r;
  assign CMD_BYTE = cmd_byte_r;
  assign CMD_ACK_EN = cmd_acken_r;

  //////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge CLK); endclocking
  default disable iff (RST || !CE);

  property p_code_late;
    $rose(FLAG) ##0 !clr_c && !abort_c |-> STATUS == `TWEC_ST_NO_INFO ##1 STATUS != `TWEC_ST_NO_INFO;
  endproperty
  a_code_late: assert property (p_code_late) else $error("status not one cycle after flag");

  property p_no_info;
    !FLAG |-> STATUS == `TWEC_ST_NO_INFO;
  endproperty
  a_no_info: assert property (p_no_info) else $error("status code without flag");

  property p_stretch;
    FLAG |-> !SCL_OE_N && !SCL_O;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock line not held");

  property p_irq_gate;
    (!FLAG || !GLOBAL_IE || !irq_en_r) |-> !IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enables");

  property p_w1c;
    FLAG && clr_c |=> !FLAG;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_w0_keep;
    FLAG && CTRL_WE && !CTRL_FLAG_W1C && !abort_c |=> FLAG;
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write");

  property p_no_op_held;
    FLAG && !clr_c && !abort_c |=> $stable(cmd_req_r);
  endproperty
  a_no_op_held: assert property (p_no_op_held) else $error("operation while flag set");

  property p_resume;
    clr_c && CTRL_ENABLE && !cmd_busy |=> cmd_req_r != $past(cmd_req_r);
  endproperty
  a_resume: assert property (p_resume) else $error("no operation after clear");

  property p_tx_nack;
    pop && en_r && hk == twec_pkg::EV_DATA_TX && !ha ##1 !clr_c && !abort_c |=> STATUS == `TWEC_ST_DTX_NACK;
  endproperty
  a_tx_nack: assert property (p_tx_nack) else $error("nack not in status");

  property p_own;
    pop && en_r && hk == twec_pkg::EV_ADDR_RX && match_own && ack_en_r ##1 !clr_c && !abort_c
      |=> STATUS == `TWEC_ST_OWN;
  endproperty
  a_own: assert property (p_own) else $error("own address not reported");

  property p_decline;
    pop && en_r && hk == twec_pkg::EV_ADDR_RX && !ack_en_r |=> !FLAG ##0 CMD_ACK_EN == 1'b0;
  endproperty
  a_decline: assert property (p_decline) else $error("address taken while disabled");

  property p_stop_tx;
    pop && hk == twec_pkg::EV_STOP_TX |=> !FLAG;
  endproperty
  a_stop_tx: assert property (p_stop_tx) else $error("flag after stop sent");

  property p_abort;
    abort_c |=> !FLAG && STATUS == `TWEC_ST_NO_INFO && !ADDR_WAKE;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort on foreign wakeup");

endmodule

// [testbench/twec_bus_model.sv]
// Bus unit model: offers queued events, takes commands.
// Assumes the bench pushes {kind, byte, ack} words into ev_q.
`timescale 1ns/1ps
module twec_bus_model (
  // Link side
  input wire logic LINK_CLK,
  input wire logic RST,
  input wire logic EV_READY,
  output logic EV_VALID = 1'b0,
  output logic [3:0] EV_KIND = 4'h0,
  output logic [7:0] EV_BYTE = 8'h00,
  output logic EV_ACK = 1'b0,
  output logic CMD_READY = 1'b0
);
  logic [12:0] ev_q[$];
  logic [12:0] w;
  ////////////////////////////////////////
  always @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      EV_VALID <= 1'b0;
      CMD_READY <= 1'b0;
    end else begin
      // Random stalls of the command taker
      CMD_READY <= 1'($urandom_range(1, 0));
      if (EV_VALID && EV_READY) begin
        EV_VALID <= 1'b0;
        // Released lines show garbage, not the last word
        {EV_KIND, EV_BYTE, EV_ACK} <= ~{EV_KIND, EV_BYTE, EV_ACK};
      end else if (!EV_VALID && ev_q.size() > 0) begin
        w = ev_q.pop_front();
        EV_VALID <= 1'b1;
        {EV_KIND, EV_BYTE, EV_ACK} <= w;
      end
    end
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the two-wire event control block.
// Assumes the bus model on the link side; software is driven here.
`timescale 1ns/1ps
`include "twec_params.svh"
module testbench;
  ////////////////////////////////////////
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic ctrl_we = 1'b0;
  logic w1c = 1'b0;
  logic c_start = 1'b0;
  logic c_stop = 1'b0;
  logic c_ack = 1'b0;
  logic c_ie = 1'b0;
  logic gie = 1'b0;
  logic [6:0] own = 7'h01;
  logic gc_en = 1'b0;
  logic data_we = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic sleep = 1'b0;
  logic other_wake = 1'b0;
  logic ev_valid, ev_ack, ev_ready, cmd_valid, cmd_ack_en, cmd_ready;
  logic [3:0] ev_kind;
  logic [7:0] ev_byte, cmd_byte, data_rdata, status, se;
  logic [2:0] cmd_code;
  logic scl_o, scl_oe_n, flag, irq, addr_wake;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] exp_st_q[$];
  logic [13:0] exp_cmd_q[$];
  logic [13:0] e;
  logic [7:0] dbyte = 8'h00;
  logic written = 1'b0;
  logic fl_p = 1'b0;
  logic pend = 1'b0;

  always #4 clk = ~clk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  twec_top dut (.CLK(clk), .RST(rst), .CE(1'b1), .LINK_CLK(link_clk), .EV_VALID(ev_valid),
    .EV_KIND(ev_kind), .EV_BYTE(ev_byte), .EV_ACK(ev_ack), .EV_READY(ev_ready), .CMD_VALID(cmd_valid),
    .CMD_CODE(cmd_code), .CMD_BYTE(cmd_byte), .CMD_ACK_EN(cmd_ack_en), .CMD_READY(cmd_ready),
    .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .CTRL_WE(ctrl_we), .CTRL_FLAG_W1C(w1c), .CTRL_START(c_start),
    .CTRL_STOP(c_stop), .CTRL_ACK_EN(c_ack), .CTRL_ENABLE(1'b1), .CTRL_IRQ_EN(c_ie), .GLOBAL_IE(gie),
    .OWN_ADDR(own), .GC_ENABLE(gc_en), .DATA_WE(data_we), .DATA_WDATA(data_wdata),
    .DATA_RDATA(data_rdata), .FLAG(flag), .STATUS(status), .IRQ(irq), .SLEEP(sleep),
    .OTHER_WAKE(other_wake), .ADDR_WAKE(addr_wake));

  twec_bus_model bus (.LINK_CLK(link_clk), .RST(rst), .EV_READY(ev_ready), .EV_VALID(ev_valid),
    .EV_KIND(ev_kind), .EV_BYTE(ev_byte), .EV_ACK(ev_ack), .CMD_READY(cmd_ready));

  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic fail_wait;
    n_mismatch++;
    $display("ERROR %0t: wait timed out", $time);
    stop_test();
  endtask

  function automatic logic [7:0] code_of(input logic [3:0] k, input logic a);
    case (k)
      twec_pkg::EV_START_TX: return `TWEC_ST_START;
      twec_pkg::EV_RSTART_TX: return `TWEC_ST_RSTART;
      twec_pkg::EV_ADDR_TX: return a ? `TWEC_ST_ATX_ACK : `TWEC_ST_ATX_NACK;
      twec_pkg::EV_DATA_TX: return a ? `TWEC_ST_DTX_ACK : `TWEC_ST_DTX_NACK;
      twec_pkg::EV_ARB_LOST: return `TWEC_ST_ARB;
      twec_pkg::EV_DATA_RX: return `TWEC_ST_DRX;
      twec_pkg::EV_STOP_RX: return `TWEC_ST_STOP_RX;
      default: return `TWEC_ST_BUS_ERR;
    endcase
  endfunction

  task automatic wait_flag;
    int i;
    @(negedge clk);
    for (i = 0; i < 2000 && flag !== 1'b1; i++) @(negedge clk);
    if (flag !== 1'b1) fail_wait();
  endtask

  task automatic wait_done;
    int i;
    for (i = 0; i < 4000 && exp_st_q.size() + exp_cmd_q.size() + bus.ev_q.size() > 0; i++) @(negedge clk);
    if (i == 4000) fail_wait();
    repeat (40) @(negedge clk);
  endtask

  task automatic ev(input logic [3:0] k, input logic a);
    if (k != twec_pkg::EV_STOP_TX) exp_st_q.push_back(code_of(k, a));
    bus.ev_q.push_back({k, 8'($urandom), a});
  endtask

  // Resume order: stop, start, send if data written, else receive
  task automatic ctrl(input logic c, st, sp, ak, ie);
    logic [2:0] cd;
    @(posedge clk);
    ctrl_we <= 1'b1;
    w1c <= c;
    c_start <= st;
    c_stop <= sp;
    c_ack <= ak;
    c_ie <= ie;
    cd = sp ? twec_pkg::CMD_STOP : st ? twec_pkg::CMD_START : written ? twec_pkg::CMD_SEND : twec_pkg::CMD_RECV;
    if (c) exp_cmd_q.push_back({cd == twec_pkg::CMD_SEND ? 2'd1 : 2'd0, cd, 1'b0, dbyte});
    if (c) written = 1'b0;
    @(posedge clk);
    ctrl_we <= 1'b0;
  endtask

  task automatic data_wr(input logic [7:0] b);
    @(posedge clk);
    data_we <= 1'b1;
    data_wdata <= b;
    @(posedge clk);
    data_we <= 1'b0;
    written = 1'b1;
    dbyte = b;
    @(negedge clk);
    check(data_rdata, b);
  endtask

  task automatic addr_ev(input logic [7:0] b, input logic clr);
    logic g, m;
    g = gc_en && b[7:1] == `TWEC_GC_ADDR;
    m = c_ack && (b[7:1] == own || g);
    exp_cmd_q.push_back({2'd2, twec_pkg::CMD_ADDR_ANS, m, 8'h00});
    if (m) exp_st_q.push_back(g ? `TWEC_ST_GC : `TWEC_ST_OWN);
    bus.ev_q.push_back({twec_pkg::EV_ADDR_RX, b, 1'b1});
    if (m) wait_flag();
    wait_done();
    check(flag, m);
    if (m) check(data_rdata, b);
    if (m && clr) ctrl(1'b1, 1'b0, 1'b0, c_ack, 1'b0);
    if (clr) wait_done();
  endtask

  ////////////////////////////////////////
  // Flag, status and stretch watcher
  always @(negedge clk) begin
    if (!rst) begin
      check(scl_oe_n, {~flag});
      check(scl_o, 1'b0);
      if (flag === 1'b1 && !fl_p) begin
        check(status, `TWEC_ST_NO_INFO);
        pend = 1'b1;
      end else if (pend) begin
        pend = 1'b0;
        se = exp_st_q.size() > 0 ? exp_st_q.pop_front() : 8'hFF;
        check(status & `TWEC_STATUS_MASK, se);
      end else if (flag === 1'b0 && !fl_p) begin
        check(status, `TWEC_ST_NO_INFO);
      end
      fl_p = flag;
    end
  end

  // Command watcher; an unexpected command never matches code 7
  always @(posedge link_clk) begin
    if (!rst && cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      e = exp_cmd_q.size() > 0 ? exp_cmd_q.pop_front() : 14'h3FFF;
      check(cmd_code, e[11:9]);
      if (e[13:12] == 2'd1) check(cmd_byte, e[7:0]);
      if (e[13:12] == 2'd2) check(cmd_ack_en, e[8]);
    end
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(25));
    own = 7'($urandom_range(126, 1));
    // Long enough for link edges too
    repeat (3) @(posedge link_clk);
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({flag, irq, scl_oe_n, ev_ready, cmd_valid, addr_wake}, 8'h0C);
    check(status, `TWEC_ST_NO_INFO);
    check(data_rdata, 8'h00);
    // Master write: start, address, data, stop
    @(posedge clk);
    gie <= 1'b1;
    ctrl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    ev(twec_pkg::EV_START_TX, 1'b1);
    wait_flag();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      gie <= i[1];
      ctrl(1'b0, 1'b0, 1'b0, 1'b1, i[0]);
      @(negedge clk);
      check(irq, i[0] & i[1]);
      check(flag, 1'b1);
    end
    wait_done();
    data_wr(8'($urandom) & 8'hFE);
    ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(twec_pkg::EV_ADDR_TX, 1'b1);
    wait_flag();
    data_wr(8'($urandom));
    ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(twec_pkg::EV_DATA_TX, 1'b0);
    wait_flag();
    ctrl(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    ev(twec_pkg::EV_STOP_TX, 1'b0);
    wait_done();
    check(flag, 1'b0);
    // Every flag-raising kind except address received
    for (int k = 0; k < 9; k++) begin
      if (k != 5) begin
        ev(4'(k), 1'($urandom));
        wait_flag();
        ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        wait_done();
      end
    end
    // Own, foreign, general call off and on, acknowledge off
    addr_ev({own, 1'b0}, 1'b1);
    addr_ev({~own, 1'b1}, 1'b1);
    addr_ev(8'h00, 1'b1);
    @(posedge clk);
    gc_en <= 1'b1;
    @(negedge clk);
    addr_ev(8'h01, 1'b1);
    ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    addr_ev({own, 1'b1}, 1'b1);
    // Match while asleep, then another wakeup aborts
    ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    sleep <= 1'b1;
    addr_ev({own, 1'b0}, 1'b0);
    check(addr_wake, 1'b1);
    exp_cmd_q.push_back({2'd0, twec_pkg::CMD_ABORT, 1'b0, 8'h00});
    @(posedge clk);
    other_wake <= 1'b1;
    wait_done();
    check({flag, addr_wake}, 8'h00);
    @(posedge clk);
    other_wake <= 1'b0;
    sleep <= 1'b0;
    // Buffer fills behind a standing flag, nothing lost
    for (int i = 0; i < 5; i++) ev(twec_pkg::EV_DATA_RX, 1'b1);
    wait_flag();
    repeat (300) @(negedge clk);
    check(ev_ready, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wait_flag();
      ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    end
    wait_done();
    stop_test();
  end
endmodule
